/* include/irqf_pkg.sv */
// Package for the interrupt request flag block: offsets, layouts, resets
package irqf_pkg;
  localparam int IRQF_FLAG_COUNT = 9;
  localparam int IRQF_PIN_COUNT = 4;
  // Printed offsets are not multiples of four: these are word indices
  localparam logic [7:0] IRQF_IDX_SERIAL0 = 8'h35;
  localparam logic [7:0] IRQF_IDX_TIMER3 = 8'h36;
  localparam logic [7:0] IRQF_IDX_TIMER2 = 8'h37;
  localparam logic [7:0] IRQF_IDX_TIMER1 = 8'h38;
  localparam logic [7:0] IRQF_IDX_TIMER0 = 8'h39;
  localparam logic [7:0] IRQF_IDX_PIN4 = 8'h3A;
  localparam logic [7:0] IRQF_IDX_PIN3 = 8'h3B;
  localparam logic [7:0] IRQF_IDX_PIN2 = 8'h3C;
  localparam logic [7:0] IRQF_IDX_PIN1 = 8'h3D;
  // Interrupt status, enable and clear registers
  localparam logic [7:0] IRQF_IDX_STATUS = 8'h40;
  localparam logic [7:0] IRQF_IDX_ENABLE = 8'h41;
  localparam logic [7:0] IRQF_IDX_CLEAR = 8'h42;
  localparam int IRQF_PENDING_BIT = 0;
  localparam int IRQF_LEVEL_BIT = 3;
  localparam logic [8:0] IRQF_FLAGS_RESET = 9'h000;
  localparam logic [8:0] IRQF_ENABLE_RESET = 9'h000;
  localparam logic [1:0] IRQF_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRQF_RESP_SLVERR = 2'h2;
  // Flag order: 0 serial0, 1..4 timer3..timer0, 5..8 pin4..pin1
  typedef struct packed {
    logic [8:0] event_pulse;
    logic [3:0] pin_level;
  } irqf_sources_t;
  typedef struct packed {
    logic [8:0] flags;
    logic [8:0] status;
    logic [8:0] enable;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic aw_held;
    logic [7:0] aw_idx;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } irqf_state_t;
endpackage

/* design/irqf_flags.sv */
// Interrupt request flag registers behind an AXI4-Lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module irqf_flags
  import irqf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic watchdog_reset,
  input wire logic serial0_event,
  input wire logic timer3_event,
  input wire logic timer2_event,
  input wire logic timer1_event,
  input wire logic timer0_event,
  input wire logic ext_pin4_event,
  input wire logic ext_pin3_event,
  input wire logic ext_pin2_event,
  input wire logic ext_pin1_event,
  input wire logic [3:0] ext_pin_level,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  irqf_state_t state_reg;
  irqf_state_t state_next;
  irqf_sources_t src;

  // Map an index to a flag number; -1 when not a flag register
  function automatic int flag_of(input logic [7:0] idx);
    if (idx == IRQF_IDX_SERIAL0) begin
      return 0;
    end else if (idx == IRQF_IDX_TIMER3) begin
      return 1;
    end else if (idx == IRQF_IDX_TIMER2) begin
      return 2;
    end else if (idx == IRQF_IDX_TIMER1) begin
      return 3;
    end else if (idx == IRQF_IDX_TIMER0) begin
      return 4;
    end else if (idx == IRQF_IDX_PIN4) begin
      return 5;
    end else if (idx == IRQF_IDX_PIN3) begin
      return 6;
    end else if (idx == IRQF_IDX_PIN2) begin
      return 7;
    end else if (idx == IRQF_IDX_PIN1) begin
      return 8;
    end else begin
      return -1;
    end
  endfunction

  // Word index from a byte address; misaligned gives an invalid index
  function automatic logic [7:0] idx_of(input logic [31:0] addr);
    if (addr[1:0] != 2'h0 || addr[31:10] != 22'h000000) begin
      return 8'hFF;
    end else begin
      return addr[9:2];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    return flag_of(idx) >= 0 || idx == IRQF_IDX_STATUS ||
      idx == IRQF_IDX_ENABLE || idx == IRQF_IDX_CLEAR;
  endfunction

  assign src.event_pulse = {ext_pin1_event, ext_pin2_event, ext_pin3_event,
    ext_pin4_event, timer0_event, timer1_event, timer2_event, timer3_event,
    serial0_event};
  assign src.pin_level = ext_pin_level;

  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign irq = |(state_reg.status & state_reg.enable);

  always_comb begin
    logic [7:0] ridx;
    logic [3:0] rword;
    int fl;
    int pin;
    logic do_write;
    logic [8:0] sw_clear;
    ridx = 8'h00;
    rword = 4'h0;
    fl = -1;
    pin = 0;
    do_write = 1'b0;
    sw_clear = 9'h000;
    state_next = state_reg;
    // Pin levels pass two flip-flops before being read
    state_next.pin_meta = src.pin_level;
    state_next.pin_sync = state_reg.pin_meta;

    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_idx = idx_of(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end

    // Write executes once address and data are both held
    if (state_reg.aw_held && state_reg.w_held) begin
      do_write = state_reg.w_strb[0];
      fl = flag_of(state_reg.aw_idx);
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = mapped(state_reg.aw_idx) ? IRQF_RESP_OKAY :
        IRQF_RESP_SLVERR;
      if (do_write && fl >= 0) begin
        state_next.flags[fl] =
          state_reg.w_data[IRQF_PENDING_BIT];
      end
      if (do_write && state_reg.aw_idx == IRQF_IDX_ENABLE) begin
        state_next.enable = state_reg.w_data[8:0];
      end
      if (state_reg.w_strb[1:0] == 2'h3 &&
          state_reg.aw_idx == IRQF_IDX_CLEAR) begin
        sw_clear = state_reg.w_data[8:0];
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Hardware events win over a software write or clear
    state_next.flags =
      state_next.flags | src.event_pulse;
    state_next.status = (state_reg.status & ~sw_clear) | src.event_pulse;

    if (s_axi_arvalid && s_axi_arready) begin
      ridx = idx_of(s_axi_araddr);
      fl = flag_of(ridx);
      rword = 4'h0;
      if (fl >= 0) begin
        rword[IRQF_PENDING_BIT] = state_reg.flags[fl];
        if (fl >= 5) begin
          pin = 8 - fl;
          rword[IRQF_LEVEL_BIT] = state_reg.pin_sync[pin[1:0]];
        end
      end
      state_next.rvalid = 1'b1;
      state_next.rresp = mapped(ridx) ? IRQF_RESP_OKAY : IRQF_RESP_SLVERR;
      if (ridx == IRQF_IDX_STATUS) begin
        state_next.rdata = {23'h000000, state_reg.status};
      end else if (ridx == IRQF_IDX_ENABLE) begin
        state_next.rdata = {23'h000000, state_reg.enable};
      end else begin
        state_next.rdata = {28'h0000000, rword};
      end
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || watchdog_reset) begin
      state_reg <= '0;
      state_reg.flags <= IRQF_FLAGS_RESET;
      state_reg.enable <= IRQF_ENABLE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

/* verification/irqf_flags_chk.sv */
// Bus and reset checker for the request flag block
`timescale 1ns/1ns
`default_nettype none
module irqf_flags_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic watchdog_reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("rvalid stuck");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write ready during bvalid");
  a_pad_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0) else $error("pad bits");
  a_wd_clear: assert property (
    watchdog_reset |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("watchdog reset ignored");
endmodule
bind irqf_flags irqf_flags_chk i_chk (.clk_sys, .rst, .watchdog_reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

/* verification/test_irqf_flags.sv */
// Self-checking bench for the request flag block
`timescale 1ns/1ns
`default_nettype none
module test_irqf_flags;
  import irqf_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, wdr = 1'h0, awv = 1'h0, wv = 1'h0;
  logic arv = 1'h0, awr, wrr, bv, arr, rv, ir;
  logic [8:0] ev = 9'h0;
  logic [3:0] lvl = 4'h0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdd;
  logic [1:0] br, rr;
  int n_mismatch = 0, checks = 0;
  localparam logic [7:0] FB = IRQF_IDX_SERIAL0;
  always #4 clk_sys = ~clk_sys;
  irqf_flags i_dut (.clk_sys, .rst, .watchdog_reset(wdr),
    .serial0_event(ev[0]), .timer3_event(ev[1]), .timer2_event(ev[2]),
    .timer1_event(ev[3]), .timer0_event(ev[4]), .ext_pin4_event(ev[5]),
    .ext_pin3_event(ev[6]), .ext_pin2_event(ev[7]),
    .ext_pin1_event(ev[8]), .ext_pin_level(lvl), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'h1), .irq(ir));
  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, g);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic w(input logic [7:0] i, input logic [31:0] d,
    input logic [1:0] xr = 2'h0);
    logic a, b, k;
    logic [1:0] q;
    awa <= {22'h0, i, 2'h0};
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(negedge clk_sys);
      a = awr;
      b = wrr;
      k = bv;
      q = br;
      @(posedge clk_sys);
      if (a) awv <= 1'h0;
      if (b) wv <= 1'h0;
    end while (!k);
    chk("bresp", {30'h0, xr}, {30'h0, q});
  endtask
  task automatic r(input logic [7:0] i, input logic [31:0] x,
    input logic [1:0] xr);
    logic a, k;
    logic [31:0] d;
    logic [1:0] q;
    ara <= {22'h0, i, 2'h0};
    arv <= 1'h1;
    do begin
      @(negedge clk_sys);
      a = arr;
      k = rv;
      d = rdd;
      q = rr;
      @(posedge clk_sys);
      if (a) arv <= 1'h0;
    end while (!k);
    if (xr == 2'h0) chk("rdata", x, d);
    chk("rresp", {30'h0, xr}, {30'h0, q});
  endtask
  task automatic p(input int k);
    ev <= 9'h1 << k;
    @(posedge clk_sys);
    ev <= 9'h0;
  endtask
  task automatic ci(input logic x);
    @(negedge clk_sys);
    chk("irq", {31'h0, x}, {31'h0, ir});
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] f(input int k, input logic q);
    return {28'h0, k > 4 ? lvl[8 - k] : 1'h0, 2'h0, q};
  endfunction
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    for (int k = 0; k < 9; k++) r(FB + 8'(k), 32'h0, 2'h0);
    for (int k = 0; k < 9; k++) begin
      p(k);
      for (int j = 0; j < 9; j++) begin
        r(FB + 8'(j), f(j, j == k), 2'h0);
      end
      w(FB + 8'(k), 32'h0);
    end
    lvl <= 4'hA;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 9; k++) begin
      w(FB + 8'(k), 32'hFFFFFFFF);
      r(FB + 8'(k), f(k, 1'h1), 2'h0);
    end
    w(8'h30, 32'h1, IRQF_RESP_SLVERR);
    r(IRQF_IDX_STATUS, 32'h1FF, 2'h0);
    ci(1'h0);
    w(IRQF_IDX_ENABLE, 32'h100);
    ci(1'h1);
    w(IRQF_IDX_CLEAR, 32'h100);
    ci(1'h0);
    r(IRQF_IDX_STATUS, 32'hFF, 2'h0);
    r(8'h30, 32'h0, IRQF_RESP_SLVERR);
    wdr <= 1'h1;
    @(posedge clk_sys);
    wdr <= 1'h0;
    r(IRQF_IDX_TIMER0, 32'h0, 2'h0);
    end_sim;
  end
endmodule
`default_nettype wire
